// ### design/ocr_best_match_selector.sv
// Purpose: keeps the best level and code over a character cycle
// Assumes: shift, start and end strobes are same-clock single-cycle pulses
// Notes:   reject replaces code when best level stays at or below minimum or the double flag is set
`timescale 1ns/1ps
module ocr_best_match_selector #(
  parameter int NMAT = 8,
  parameter int NPT  = 8
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // cycle control
  input  wire logic                 shift_i,
  input  wire logic                 cycle_start_i,
  input  wire logic                 cycle_end_i,
  // buffer controller settings
  input  ocr_sel_pkg::level_t       peak_reference_level_i,
  input  ocr_sel_pkg::level_t       min_level_i,
  input  wire logic [NMAT-1:0]      inhibit_i,
  // matrices
  input  wire logic                 black_i [NPT],
  input  wire logic [1:0]           wcode_i [NMAT][NPT],
  input  ocr_sel_pkg::pt_class_t    pclass_i[NMAT][NPT],
  input  ocr_sel_pkg::code_t        mat_code_i[NMAT],
  // comparator outputs
  output logic                      lvl_eq_o,
  output logic                      lvl_ge_o,
  output logic                      char_peak_o,
  output logic                      double_o,
  // fifo outputs
  output logic                      push_o,
  output ocr_sel_pkg::code_t        code_fifo_o,
  output ocr_sel_pkg::level_t       level_fifo_o
);
  import ocr_sel_pkg::*;
  typedef struct packed {
    logic   r1;
    logic   r2;
    level_t best_level_register;
    code_t  best_char_register;
    logic   dbl;
    logic   eq;
    logic   ge;
    logic   peak;
    logic   push;
    code_t  code_out;
    level_t level_out;
  } st_t;
  st_t st_reg;
  st_t st_next;
  level_t new_level_code;
  code_t  new_char_code;
  level_t second;
  logic   rst_n;
  assign rst_n = st_reg.r2;
  ocr_match_encoder #(.NMAT(NMAT), .NPT(NPT)) u_enc (
    .black_i    (black_i),
    .wcode_i    (wcode_i),
    .pclass_i   (pclass_i),
    .inhibit_i  (inhibit_i),
    .mat_code_i (mat_code_i),
    .level_o    (new_level_code),
    .code_o     (new_char_code),
    .second_o   (second)
  );
  always_comb begin
    logic near;
    near = (5'(new_level_code) <= 5'(second) + 5'(`DBL_MARGIN)) && (new_level_code != '0);
    st_next = st_reg;
    st_next.r1 = 1'b1;
    st_next.r2 = st_reg.r1;
    st_next.push = 1'b0;
    if (cycle_start_i) begin
      st_next.best_level_register = `BEST_LVL_RST;
      st_next.best_char_register  = `BEST_CODE_RST;
      st_next.dbl = 1'b0;
    end else if (shift_i) begin
      st_next.eq   = (new_level_code == st_reg.best_level_register);
      st_next.ge   = (new_level_code >= st_reg.best_level_register);
      st_next.peak = (new_level_code > peak_reference_level_i);
      if (new_level_code > st_reg.best_level_register) begin
        st_next.best_level_register = new_level_code;
        st_next.best_char_register  = new_char_code;
        st_next.dbl = near;
      end else if (new_level_code == st_reg.best_level_register && near) begin
        st_next.dbl = 1'b1;
      end // otherwise unchanged
    end
    if (cycle_end_i) begin
      st_next.push = 1'b1;
      st_next.level_out = st_reg.best_level_register;
      st_next.code_out = (st_reg.best_level_register <= min_level_i || st_reg.dbl)
                         ? `REJECT_CODE : st_reg.best_char_register;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else if (!st_reg.r2) begin
      st_reg <= '0;
      st_reg.r1 <= 1'b1;
      st_reg.r2 <= st_reg.r1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lvl_eq_o     = st_reg.eq;
  assign lvl_ge_o     = st_reg.ge;
  assign char_peak_o  = st_reg.peak;
  assign double_o     = st_reg.dbl;
  assign push_o       = st_reg.push;
  assign code_fifo_o  = st_reg.code_out;
  assign level_fifo_o = st_reg.level_out;

  a_clear_best: assert property (@(posedge clk_i) disable iff (!rst_n)
    cycle_start_i |=> st_reg.best_level_register == '0 && st_reg.best_char_register == '0)
    else $error("best not cleared");
  a_load_best: assert property (@(posedge clk_i) disable iff (!rst_n)
    shift_i && !cycle_start_i && new_level_code > st_reg.best_level_register
    |=> st_reg.best_level_register == $past(new_level_code))
    else $error("best level not loaded");
  a_hold_best: assert property (@(posedge clk_i) disable iff (!rst_n)
    !cycle_start_i && !(shift_i && new_level_code > st_reg.best_level_register)
    |=> $stable(st_reg.best_level_register) && $stable(st_reg.best_char_register))
    else $error("best changed without cause");
  a_push_out: assert property (@(posedge clk_i) disable iff (!rst_n)
    cycle_end_i |=> push_o && level_fifo_o == $past(st_reg.best_level_register)
      ##1 (!push_o || $past(cycle_end_i)))
    else $error("push wrong");
  a_peak_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    shift_i && !cycle_start_i
    |=> char_peak_o == ($past(new_level_code) > $past(peak_reference_level_i)))
    else $error("peak flag wrong");
  a_cmp_ge: assert property (@(posedge clk_i) disable iff (!rst_n)
    shift_i && !cycle_start_i
    |=> lvl_ge_o == ($past(new_level_code) >= $past(st_reg.best_level_register)))
    else $error("ge wrong");
  a_reject_low: assert property (@(posedge clk_i) disable iff (!rst_n)
    cycle_end_i && st_reg.best_level_register <= min_level_i |=> code_fifo_o == `REJECT_CODE)
    else $error("reject missing");
  a_level_rise: assert property (@(posedge clk_i) disable iff (!rst_n)
    !cycle_start_i |=> st_reg.best_level_register >= $past(st_reg.best_level_register))
    else $error("best level fell");
  c_new_best: cover property (@(posedge clk_i) shift_i && new_level_code > st_reg.best_level_register);
  c_push:     cover property (@(posedge clk_i) push_o);
  c_reject:   cover property (@(posedge clk_i) push_o && code_fifo_o == `REJECT_CODE);
  c_double:   cover property (@(posedge clk_i) double_o);
endmodule : ocr_best_match_selector

// ### design/ocr_match_encoder.sv
// Purpose: weighted matrix sums, inhibit, winner encode and level quantise
// Assumes: sample points and weights come from same-clock image logic
// Notes:   sums are saturated into 16 steps; lowest index wins a tie
`timescale 1ns/1ps
module ocr_match_encoder #(
  parameter int NMAT = 8,
  parameter int NPT  = 8
) (
  // image and matrices
  input  wire logic                      black_i [NPT],
  input  wire logic [1:0]                wcode_i [NMAT][NPT],
  input  ocr_sel_pkg::pt_class_t         pclass_i[NMAT][NPT],
  input  wire logic [NMAT-1:0]           inhibit_i,
  input  ocr_sel_pkg::code_t             mat_code_i[NMAT],
  // results
  output ocr_sel_pkg::level_t            level_o,
  output ocr_sel_pkg::code_t             code_o,
  output ocr_sel_pkg::level_t            second_o
);
  import ocr_sel_pkg::*;
  logic signed [15:0] sum [NMAT];
  logic [NMAT-1:0]    win;
  genvar m;
  generate
    for (m = 0; m < NMAT; m++) begin : g_mat
      always_comb begin
        logic signed [15:0] s;
        logic signed [15:0] w;
        s = '0;
        w = '0;
        for (int p = 0; p < NPT; p++) begin
          w = 16'(wcode_i[m][p]) + 16'sd1;
          case (pclass_i[m][p])
            PT_RES: s = black_i[p] ? s + w : s - w;
            PT_DIO: s = black_i[p] ? s : s - w;
            default: s = black_i[p] ? s - w : s;
          endcase
        end
        sum[m] = inhibit_i[m] ? -16'sd32767 : s;
      end
    end
  endgenerate
  always_comb begin
    int bi;
    logic signed [15:0] b1;
    logic signed [15:0] b2;
    bi = 0;
    b1 = sum[0];
    b2 = -16'sd32768;
    for (int i = 1; i < NMAT; i++) begin
      if (sum[i] > b1) begin
        b2 = b1;
        b1 = sum[i];
        bi = i;
      end else if (sum[i] > b2) begin
        b2 = sum[i];
      end
    end
    win = '0;
    win[bi] = 1'b1;
    code_o = '0;
    for (int i = 0; i < NMAT; i++) begin
      if (win[i]) code_o = mat_code_i[i];
    end
    level_o  = (b1 <= 0) ? '0 : (b1 >= `LEVEL_STEPS-1) ? 4'hf : b1[3:0];
    second_o = (b2 <= 0) ? '0 : (b2 >= `LEVEL_STEPS-1) ? 4'hf : b2[3:0];
  end
endmodule : ocr_match_encoder

// ### design/ocr_sel_consts.svh
// Purpose: constants for the best-match selector
// Assumes: one 100 MHz clock, shift strobes from same-clock logic
// Notes:   timing counts are in shift strobes, not clock cycles
// Contract
// - selection state, best level and best code, is cleared at each cycle start.
// - each shift strobe takes one 4-bit level and one 7-bit code as the candidate.
// - a new level above the best level by one or more loads level and code as best.
// - a new level not above the best leaves best level and code unchanged.
// - at cycle end the retained code and level are pushed to the code and level FIFOs.
// - a new level above the peak reference level raises the character peak flag.
// - equal and greater-or-equal of new against best level go out each shift.
// - a reject code replaces the code when the cycle fails the acceptance minimums.
// - the match level is quantised to 16 steps as a 4-bit code.
// - the winning matrix identity is encoded to a 7-bit character code.
// - exactly one matrix wins per shift and is encoded as one-hot.
// - inhibited matrix groups are forced to worst match and can win only when every matrix is inhibited.
// - two near-equal matches within the double margin flag a character double.
// - each sample point has weight 1 to 4 in resistor, diode and negation classes.
// - resistor points add when black and subtract when white; diode points only subtract when white.
// - negation points subtract when black and do nothing when white.
`ifndef OCR_SEL_CONSTS_SVH
`define OCR_SEL_CONSTS_SVH
`define LEVEL_W       4
`define CODE_W        7
`define LEVEL_STEPS   16
`define BEST_LVL_RST  4'h0
`define BEST_CODE_RST 7'h00
`define REJECT_CODE   7'h3f
`define MIN_LEVEL_DEF 4'h4
`define DBL_MARGIN    4'h1
`endif

// ### design/ocr_sel_pkg.sv
// Purpose: types for the best-match selector
// Assumes: constants header included
// Notes:   weight classes per sample point
`include "ocr_sel_consts.svh"
package ocr_sel_pkg;
  typedef logic [`LEVEL_W-1:0] level_t;
  typedef logic [`CODE_W-1:0]  code_t;
  typedef enum logic [2:0] {
    PT_RES  = 3'b001,
    PT_DIO  = 3'b010,
    PT_NEG  = 3'b100
  } pt_class_t;
endpackage : ocr_sel_pkg

// ### testbench/cyc_ctrl_model.sv
// Purpose: cycle control model giving start, shift and end strobes
// Assumes: strobes change 1 ns after the rising edge
// Notes:   strobes idle low between pulses
`timescale 1ns/1ps
module cyc_ctrl_model (
  // clock
  input  wire logic clk_i,
  // strobes
  output logic      shift_o,
  output logic      start_o,
  output logic      end_o
);
  initial begin
    {shift_o, start_o, end_o} = 3'h0;
  end
  // one-clock pulse; a start never shares a pulse with a shift
  task automatic pulse(input logic sh, input logic st, input logic en);
    @(posedge clk_i);
    #1;
    {shift_o, start_o, end_o} = {sh, st, en};
    @(posedge clk_i);
    #1;
    {shift_o, start_o, end_o} = 3'h0;
  endtask : pulse
endmodule : cyc_ctrl_model

// ### testbench/test_ocr_best_match_selector.sv
// Purpose: self-checking bench for the best-match selector
// Assumes: two matrices of four points, every image point black
// Notes:   diode points add nothing on black, so they pad short sums
`timescale 1ns/1ps
`include "ocr_sel_consts.svh"
module test_ocr_best_match_selector;
  import ocr_sel_pkg::*;
  logic      clk_i  = 1'b0;
  logic      nrst_i = 1'b0;
  logic      shift, start, cend, eq, ge, peak, dbl, push;
  level_t    pref, minl, lvl_f, best;
  code_t     code_f, bcode;
  logic [1:0] inh;
  logic      black[4];
  logic [1:0] wc[2][4];
  pt_class_t pc[2][4];
  code_t     mc[2];
  int        mismatches  = 0;
  int        check_count = 0;
  always #5 clk_i = ~clk_i;
  cyc_ctrl_model cyc_ctrl_model_i (.clk_i(clk_i), .shift_o(shift), .start_o(start), .end_o(cend));
  ocr_best_match_selector #(.NMAT(2), .NPT(4)) ocr_best_match_selector_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .shift_i(shift), .cycle_start_i(start),
    .cycle_end_i(cend), .peak_reference_level_i(pref), .min_level_i(minl),
    .inhibit_i(inh), .black_i(black), .wcode_i(wc), .pclass_i(pc), .mat_code_i(mc),
    .lvl_eq_o(eq), .lvl_ge_o(ge), .char_peak_o(peak), .double_o(dbl),
    .push_o(push), .code_fifo_o(code_f), .level_fifo_o(lvl_f));
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // resistor points carry up to 4 each, the rest are diode points
  task automatic set_mat(input int m, input int l);
    int r;
    r = l;
    for (int p = 0; p < 4; p++) begin
      pc[m][p] = (r > 0) ? PT_RES : PT_DIO;
      wc[m][p] = 2'((r > 4) ? 3 : ((r > 0) ? r - 1 : 0));
      r = r - ((r > 4) ? 4 : r);
    end
  endtask : set_mat
  task automatic begin_cycle;
    cyc_ctrl_model_i.pulse(1'b0, 1'b1, 1'b0);
    @(posedge clk_i);
    #1;
    best = 4'h0;
    bcode = 7'h00;
    check("double", dbl, 1'b0);
  endtask : begin_cycle
  task automatic shift_in(input int l0, input int l1, input code_t c);
    logic   m1;
    level_t nl;
    set_mat(0, l0);
    set_mat(1, l1);
    mc[0] = c;
    m1 = inh[0] || l1 > l0;
    nl = level_t'(((m1 ? l1 : l0) > 15) ? 15 : (m1 ? l1 : l0));
    cyc_ctrl_model_i.pulse(1'b1, 1'b0, 1'b0);
    @(posedge clk_i);
    #1;
    check("lvl_eq", eq, nl == best);
    check("lvl_ge", ge, nl >= best);
    check("char_peak", peak, nl > pref);
    if (nl > best) begin
      best = nl;
      bcode = m1 ? mc[1] : c;
    end
  endtask : shift_in
  task automatic finish_cycle(input string name, input logic d);
    cyc_ctrl_model_i.pulse(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4 && push !== 1'b1; i++) @(posedge clk_i) #1;
    check("push", push, 1'b1);
    check("code_fifo", code_f, (best <= minl || d) ? `REJECT_CODE : bcode);
    check("level_fifo", lvl_f, best);
    check("double", dbl, d);
    $display("test %s done", name);
  endtask : finish_cycle
  initial begin
    pref = 4'h8;
    minl = `MIN_LEVEL_DEF;
    inh = 2'h0;
    foreach (black[p]) black[p] = 1'b1;
    mc[1] = 7'h31;
    set_mat(0, 0);
    set_mat(1, 0);
    mc[0] = 7'h00;
    repeat (4) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    begin_cycle();
    shift_in(5, 0, 7'h41);
    shift_in(3, 0, 7'h42);
    shift_in(9, 0, 7'h43);
    shift_in(9, 0, 7'h44);
    shift_in(7, 0, 7'h45);
    finish_cycle("highest kept", 1'b0);
    begin_cycle();
    shift_in(16, 0, 7'h50);
    shift_in(15, 0, 7'h51);
    finish_cycle("saturated level", 1'b0);
    begin_cycle();
    shift_in(4, 0, 7'h52);
    shift_in(3, 0, 7'h53);
    finish_cycle("minimum reject", 1'b0);
    inh = 2'h1;
    begin_cycle();
    shift_in(12, 6, 7'h54);
    finish_cycle("inhibit", 1'b0);
    inh = 2'h0;
    begin_cycle();
    shift_in(8, 7, 7'h55);
    finish_cycle("double reject", 1'b1);
    conclude();
  end
  // whole run is under a hundred cycles
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule : test_ocr_best_match_selector
